// File: pmev_top.sv
// Event and power-saving enable logic of the metering calculation unit
`timescale 1ns/10ps
`include "pmev_cfg.svh"
// Overview of operation
// - Reactive half-full event at half range
// - Reactive overflow or underflow event
// - Reactive no-load event on falling below threshold
// - Reactive no-load thresholds 0,13a,9d,4d
// - Rising above threshold raises nothing
// - Apparent no-load event on falling below threshold
// - Apparent thresholds 0,275,13a,9d
// - Ampere-hour mode compares current RMS, other thresholds
// - Current RMS padded with two zero LSBs
// - Cycle-end event when half-cycles equal number
// - Cycle-end disable suppresses event
// - Waveform event when selected sample changes
// - Sample registers refresh at 4.34 kHz
// - Master enable gates all calculations
// - Wiring mode selects two or three wire
// - Active disable stops active calculation
// - Reactive disable stops reactive calculation
// - Apparent disable stops apparent and ampere-hour
// - Ampere-hour select picks accumulated quantity
module pmev_top
    import pmev_pkg::*;
#(
    parameter int SAMPLE_CYC = `PMEV_SAMPLE_CYC,
    parameter int LINE_W     = `PMEV_LINE_W
) (
    input  wire logic                    mclk_i,              // Main clock
    input  wire logic                    sys_rst_i,           // Synchronous reset
    input  wire logic                    acc_tick_i,          // Accumulation tick
    input  wire logic [7:0]              power_control_one_i, // Control register 1
    input  wire logic [7:0]              power_control_two_i, // Control register 2
    input  wire logic [7:0]              converter_mode_two_i,// Converter mode register 2
    input  wire pmev_pkg::pmev_nl_code_t reactive_noload_code_i, // Reactive level hi:lo
    input  wire pmev_pkg::pmev_nl_code_t apparent_noload_code_i, // Apparent level hi:lo
    input  wire logic                    cycle_end_disable_i, // Cycle-end disable
    input  wire logic [LINE_W-1:0]       line_cycle_number_i, // Half-cycles per period
    input  wire logic                    half_cycle_i,        // Half-line-cycle pulse
    input  wire logic [41:40]            rea_acc_top_i,       // Reactive accumulator top bits
    input  wire logic [41:40]            app_acc_top_i,       // Apparent accumulator top bits
    input  wire logic [24:0]             reactive_power_i,    // Signed reactive power
    input  wire logic [24:0]             apparent_power_i,    // Apparent power
    input  wire logic [22:0]             current_rms_i,       // Current RMS
    input  wire logic                    sample_enable_bit_i, // Waveform sampling enable
    input  wire pmev_pkg::pmev_sel_t     sample_source_select_i [2], // Source per sample
    input  wire logic [24:0]             sample_data_i [8],   // Candidate waveform signals
    output logic                         reactive_energy_half_event_o,     // Pulse
    output logic                         reactive_energy_overflow_event_o, // Pulse
    output logic                         reactive_noload_event_o,          // Pulse
    output logic                         apparent_energy_half_event_o,     // Pulse
    output logic                         apparent_energy_overflow_event_o, // Pulse
    output logic                         apparent_noload_event_o,          // Pulse
    output logic                         cycle_end_event_o,                // Pulse
    output logic                         waveform_sample_event_o,          // Pulse
    output logic [24:0]                  wave_sample_first_o,  // Sample register 1
    output logic [24:0]                  wave_sample_second_o, // Sample register 2
    output logic                         active_calc_en_o,     // Active calc running
    output logic                         reactive_calc_en_o,   // Reactive calc running
    output logic                         apparent_calc_en_o,   // Apparent calc running
    output logic                         amp_hour_acc_en_o,    // Ampere-hour acc running
    output logic                         second_channel_en_o   // Channel 2 in use
);
    import pmev_pkg::*;

    // Threshold decode used by both no-load comparators
    function automatic logic [24:0] nl_thresh(input logic [1:0] code,
                                              input logic [24:0] t1,
                                              input logic [24:0] t2,
                                              input logic [24:0] t3);
        case (code)
            2'h1:    nl_thresh = t1;
            2'h2:    nl_thresh = t2;
            2'h3:    nl_thresh = t3;
            default: nl_thresh = 25'h0;
        endcase
    endfunction

    typedef struct packed {
        logic [31:0]       samp_cnt;
        logic [LINE_W-1:0] half_cnt;
        logic              rea_below;
        logic              app_below;
        logic              rea_nl;
        logic              app_nl;
        logic              cyc;
        logic              wf;
        logic [24:0]       wave_a;
        logic [24:0]       wave_b;
        logic              act_en;
        logic              rea_en;
        logic              app_en;
        logic              ah_en;
        logic              ch2_en;
    } pmev_state_t;

    pmev_state_t st_ff;
    pmev_state_t nxt_st;

    logic        pwr_en;
    logic        ah_sel;
    logic        wire3;
    logic [24:0] rea_abs;
    logic [24:0] rea_thr;
    logic [24:0] app_thr;
    logic [24:0] app_val;
    logic        rea_below_now;
    logic        app_below_now;
    logic        samp_tick;
    logic [24:0] sel1;
    logic [24:0] sel2;
    logic        rea_half;
    logic        rea_ovf;
    logic        app_half;
    logic        app_ovf;

    assign pwr_en = power_control_one_i[`PMEV_CTL1_EN_BIT];
    assign ah_sel = power_control_one_i[`PMEV_CTL1_AH_BIT];
    assign wire3  = converter_mode_two_i[`PMEV_CONV2_WIRE_BIT];

    assign rea_abs = reactive_power_i[24] ? 25'(-reactive_power_i) : reactive_power_i;
    assign rea_thr = nl_thresh(reactive_noload_code_i, `PMEV_NL_REA_01,
                               `PMEV_NL_REA_10, `PMEV_NL_REA_11);
    assign app_thr = ah_sel ? nl_thresh(apparent_noload_code_i, `PMEV_NL_AH_01,
                                        `PMEV_NL_AH_10, `PMEV_NL_AH_11)
                            : nl_thresh(apparent_noload_code_i, `PMEV_NL_APP_01,
                                        `PMEV_NL_APP_10, `PMEV_NL_APP_11);
    // Current RMS gains two zero LSBs to line up with 25-bit power
    assign app_val = ah_sel ? {current_rms_i, 2'b00} : apparent_power_i;
    assign rea_below_now = rea_abs < rea_thr;
    assign app_below_now = app_val < app_thr;

    assign samp_tick = (st_ff.samp_cnt >= 32'(SAMPLE_CYC - 1));
    assign sel1 = sample_data_i[sample_source_select_i[0]];
    assign sel2 = sample_data_i[sample_source_select_i[1]];

    pmev_acc_mon #(
        .SIGNED_ACC (1'b1)
    ) u_rea_mon (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (acc_tick_i & st_ff.rea_en),
        .top_i     (rea_acc_top_i),
        .half_o    (rea_half),
        .ovf_o     (rea_ovf)
    );

    pmev_acc_mon #(
        .SIGNED_ACC (1'b0)
    ) u_app_mon (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .tick_i    (acc_tick_i & (st_ff.app_en | st_ff.ah_en)),
        .top_i     (app_acc_top_i),
        .half_o    (app_half),
        .ovf_o     (app_ovf)
    );

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.rea_nl = 1'b0;
        nxt_st.cyc    = 1'b0;
        nxt_st.wf     = 1'b0;
        nxt_st.app_nl = 1'b0;
        nxt_st.act_en = pwr_en & ~power_control_two_i[`PMEV_CTL2_ACT_BIT];
        nxt_st.rea_en = pwr_en & ~power_control_one_i[`PMEV_CTL1_REA_BIT];
        nxt_st.app_en = pwr_en & ~power_control_one_i[`PMEV_CTL1_APP_BIT] & ~ah_sel;
        nxt_st.ah_en  = pwr_en & ~power_control_one_i[`PMEV_CTL1_APP_BIT] & ah_sel;
        nxt_st.ch2_en = pwr_en & wire3;
        if (acc_tick_i) begin
            // Only the falling edge across the threshold counts
            nxt_st.rea_below = rea_below_now;
            nxt_st.app_below = app_below_now;
            nxt_st.rea_nl = st_ff.rea_en & rea_below_now & ~st_ff.rea_below;
            nxt_st.app_nl = (st_ff.app_en | st_ff.ah_en)
                            & app_below_now & ~st_ff.app_below;
        end
        if (half_cycle_i && pwr_en) begin
            if (st_ff.half_cnt + LINE_W'(1) >= line_cycle_number_i) begin
                nxt_st.half_cnt = '0;
                nxt_st.cyc = ~cycle_end_disable_i;
            end else begin
                nxt_st.half_cnt = st_ff.half_cnt + LINE_W'(1);
            end
        end
        if (samp_tick) begin
            nxt_st.samp_cnt = '0;
        end else begin
            nxt_st.samp_cnt = st_ff.samp_cnt + 32'h1;
        end
        // Refresh once per sample period; reads have no side effects
        if (samp_tick && sample_enable_bit_i && pwr_en) begin
            nxt_st.wave_a = sel1;
            nxt_st.wave_b = sel2;
            nxt_st.wf = (sel1 != st_ff.wave_a) | (sel2 != st_ff.wave_b);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign reactive_energy_half_event_o     = rea_half;
    assign reactive_energy_overflow_event_o = rea_ovf;
    assign apparent_energy_half_event_o     = app_half;
    assign apparent_energy_overflow_event_o = app_ovf;
    assign reactive_noload_event_o = st_ff.rea_nl;
    assign apparent_noload_event_o = st_ff.app_nl;
    assign cycle_end_event_o       = st_ff.cyc;
    assign waveform_sample_event_o = st_ff.wf;
    assign wave_sample_first_o     = st_ff.wave_a;
    assign wave_sample_second_o    = st_ff.wave_b;
    assign active_calc_en_o        = st_ff.act_en;
    assign reactive_calc_en_o      = st_ff.rea_en;
    assign apparent_calc_en_o      = st_ff.app_en;
    assign amp_hour_acc_en_o       = st_ff.ah_en;
    assign second_channel_en_o     = st_ff.ch2_en;

    master_off_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !pwr_en |=> !(reactive_calc_en_o | apparent_calc_en_o | active_calc_en_o))
        else $error("calc enabled while master off");
    cyc_disable_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        cycle_end_disable_i |=> !cycle_end_event_o)
        else $error("cycle end not suppressed");
    rea_rise_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (acc_tick_i && !rea_below_now) |=> !reactive_noload_event_o)
        else $error("no-load on rise");
    app_excl_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !(apparent_calc_en_o && amp_hour_acc_en_o))
        else $error("apparent and ampere-hour both on");
    samp_hold_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !$past(samp_tick) |-> $stable(wave_sample_first_o))
        else $error("sample changed off tick");
    wf_tick_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        waveform_sample_event_o |-> $past(samp_tick))
        else $error("waveform event off tick");
    app_pos_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        (acc_tick_i && app_acc_top_i == 2'h1 && amp_hour_acc_en_o) ##1
        (acc_tick_i && app_acc_top_i == 2'h0) |=> !apparent_energy_overflow_event_o)
        else $error("apparent underflow flagged");
    rea_disable_a: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        power_control_one_i[`PMEV_CTL1_REA_BIT] |=> !reactive_calc_en_o ##1
        !reactive_noload_event_o)
        else $error("reactive not stopped");
endmodule

// File: pmev_cfg.svh
// Constants for the power meter event logic
`ifndef PMEV_CFG_SVH
`define PMEV_CFG_SVH
`define PMEV_ACC_W        42
`define PMEV_PWR_W        25
`define PMEV_IRMS_W       23
`define PMEV_SAMP_W       25
`define PMEV_LINE_W       16
`define PMEV_SEL_W        3
`define PMEV_NL_REA_01    25'h0000013a
`define PMEV_NL_REA_10    25'h0000009d
`define PMEV_NL_REA_11    25'h0000004d
`define PMEV_NL_APP_01    25'h00000275
`define PMEV_NL_APP_10    25'h0000013a
`define PMEV_NL_APP_11    25'h0000009d
`define PMEV_NL_AH_01     25'h00000379
`define PMEV_NL_AH_10     25'h000001bc
`define PMEV_NL_AH_11     25'h000000de
`define PMEV_CTL1_EN_BIT  7
`define PMEV_CTL1_REA_BIT 6
`define PMEV_CTL1_APP_BIT 5
`define PMEV_CTL1_AH_BIT  2
`define PMEV_CTL2_ACT_BIT 7
`define PMEV_CONV2_WIRE_BIT 5
`define PMEV_SAMPLE_HZ    4340
`define PMEV_CLK_HZ       250000000
`define PMEV_SAMPLE_CYC   (`PMEV_CLK_HZ / `PMEV_SAMPLE_HZ)
`endif

// File: pmev_pkg.sv
// Types for the power meter event logic
package pmev_pkg;
    typedef logic [1:0] pmev_nl_code_t;
    typedef logic [2:0] pmev_sel_t;
endpackage

// File: pmev_acc_mon.sv
// Half-full and overflow monitor for one 42-bit energy accumulator
`timescale 1ns/10ps
`include "pmev_cfg.svh"
module pmev_acc_mon #(
    parameter bit SIGNED_ACC = 1'b1
) (
    input  wire logic       mclk_i,      // Main clock
    input  wire logic       sys_rst_i,   // Synchronous reset
    input  wire logic       tick_i,      // Accumulation tick
    input  wire logic [1:0] top_i,       // Accumulator bits 41:40
    output logic            half_o,      // Half-full pulse
    output logic            ovf_o        // Overflow pulse
);
    typedef struct packed {
        logic [1:0] prev;
        logic       half;
        logic       ovf;
    } pmev_mon_t;
    pmev_mon_t st_ff;
    pmev_mon_t nxt_st;

    always_comb begin
        nxt_st      = st_ff;
        nxt_st.half = 1'b0;
        nxt_st.ovf  = 1'b0;
        if (tick_i) begin
            nxt_st.prev = top_i;
            // Positive: 00->01 half, 01->10 overflow
            if (st_ff.prev == 2'h0 && top_i == 2'h1) begin
                nxt_st.half = 1'b1;
            end
            if (st_ff.prev == 2'h1 && top_i == 2'h2) begin
                nxt_st.ovf = 1'b1;
            end
            // Negative: 11->10 half, 10->01 underflow; unsigned sees no sign
            if (SIGNED_ACC && st_ff.prev == 2'h3 && top_i == 2'h2) begin
                nxt_st.half = 1'b1;
            end
            if (SIGNED_ACC && st_ff.prev == 2'h2 && top_i == 2'h1) begin
                nxt_st.ovf = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign half_o = st_ff.half;
    assign ovf_o  = st_ff.ovf;
endmodule

// File: test_pmev_top.sv
// Self-checking testbench for the power meter event logic
`timescale 1ns/10ps
module test_pmev_top;
    import pmev_pkg::*;
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
    // Short sample period keeps the waveform scenarios brief
    localparam int SAMP = 8;
    localparam logic [23:0] EN_STIM [4] = '{24'h000020, 24'h808000, 24'he40020, 24'h840020};
    localparam logic [4:0]  EN_EXP  [4] = '{5'b00000, 5'b01100, 5'b10001, 5'b11011};
    localparam logic [3:0]  ACC_TOP [7] = '{4'h0, 4'h5, 4'ha, 4'hf, 4'ha, 4'h5, 4'h0};
    localparam logic [7:0]  ACC_EXP [7] = '{8'h00, 8'h09, 8'h12, 8'h00, 8'h01, 8'h02, 8'h00};
    localparam logic [24:0] REA_THR [4] = '{25'h0, 25'h13a, 25'h09d, 25'h04d};
    localparam logic [24:0] APP_THR [8] = '{25'h0, 25'h275, 25'h13a, 25'h09d,
                                            25'h0, 25'h379, 25'h1bc, 25'h0de};
    logic          mclk_i, sys_rst_i, acc_tick, half_cyc, cyc_dis, samp_en;
    logic [7:0]    pc1, pc2, cmr2, evbus, seen;
    pmev_nl_code_t rea_code, app_code;
    logic [15:0]   line_num;
    logic [1:0]    rea_top, app_top;
    logic [24:0]   rea_pwr, app_pwr, wva, wvb, rt, at, mag;
    logic [22:0]   irms;
    pmev_sel_t     sel [2];
    logic [24:0]   sdata [8];
    logic          ev_rh, ev_ro, ev_rn, ev_ah, ev_ao, ev_an, ev_ce, ev_wf;
    logic          en_act, en_rea, en_app, en_ahr, en_ch2;
    int            ce_cnt, failures, cmp_count;

    assign evbus = {ev_wf, ev_ce, ev_an, ev_ao, ev_ah, ev_rn, ev_ro, ev_rh};

    pmev_top #(.SAMPLE_CYC(SAMP), .LINE_W(16)) dut_u (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .acc_tick_i(acc_tick),
        .power_control_one_i(pc1), .power_control_two_i(pc2), .converter_mode_two_i(cmr2),
        .reactive_noload_code_i(rea_code), .apparent_noload_code_i(app_code),
        .cycle_end_disable_i(cyc_dis), .line_cycle_number_i(line_num),
        .half_cycle_i(half_cyc), .rea_acc_top_i(rea_top), .app_acc_top_i(app_top),
        .reactive_power_i(rea_pwr), .apparent_power_i(app_pwr), .current_rms_i(irms),
        .sample_enable_bit_i(samp_en), .sample_source_select_i(sel), .sample_data_i(sdata),
        .reactive_energy_half_event_o(ev_rh), .reactive_energy_overflow_event_o(ev_ro),
        .reactive_noload_event_o(ev_rn), .apparent_energy_half_event_o(ev_ah),
        .apparent_energy_overflow_event_o(ev_ao), .apparent_noload_event_o(ev_an),
        .cycle_end_event_o(ev_ce), .waveform_sample_event_o(ev_wf),
        .wave_sample_first_o(wva), .wave_sample_second_o(wvb),
        .active_calc_en_o(en_act), .reactive_calc_en_o(en_rea), .apparent_calc_en_o(en_app),
        .amp_hour_acc_en_o(en_ahr), .second_channel_en_o(en_ch2)
    );

    always #2 mclk_i = ~mclk_i;

    // Every pulse seen in a cycle is kept, so the exact answer cycle does not matter
    task automatic cyc(input int n);
        repeat (n) begin
            @(posedge mclk_i);
            #1;
            seen = seen | evbus;
            if (ev_ce === 1'b1) ce_cnt++;
        end
    endtask

    task automatic tick();
        acc_tick = 1'b1;
        cyc(1);
        acc_tick = 1'b0;
        cyc(3);
    endtask

    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic test_enables();
        for (int i = 0; i < 4; i++) begin
            {pc1, pc2, cmr2} = EN_STIM[i];
            cyc(2);
            `CHK({en_act, en_rea, en_app, en_ahr, en_ch2}, EN_EXP[i])
        end
    endtask

    task automatic test_accum();
        {pc1, pc2, cmr2} = 24'h800000;
        for (int i = 0; i < 7; i++) begin
            {rea_top, app_top} = ACC_TOP[i];
            seen = 8'h00;
            tick();
            `CHK(seen & 8'h1b, ACC_EXP[i])
        end
        // Reactive calculation off must silence its half-full event
        pc1 = 8'hc0;
        // The enable lags one cycle; let it settle before the tick
        cyc(1);
        {rea_top, app_top} = 4'h5;
        seen = 8'h00;
        tick();
        `CHK(seen & 8'h1b, 8'h08)
    endtask

    task automatic test_noload();
        for (int c = 1; c < 4; c++) begin
            for (int a = 0; a < 2; a++) begin
                rt = REA_THR[c];
                at = APP_THR[a*4+c];
                pc1 = (a != 0) ? 8'h84 : 8'h80;
                rea_code = 2'(c);
                app_code = 2'(c);
                for (int s = 0; s < 4; s++) begin
                    mag = s[0] ? rt - 25'h1 : rt + 25'h1;
                    rea_pwr = s[1] ? 25'h0 - mag : mag;
                    if (a != 0) begin
                        app_pwr = 25'h0ffff;
                        irms = s[0] ? 23'((at - 25'h1) >> 2) : 23'((at >> 2) + 25'h1);
                    end else begin
                        irms = 23'h7ffff;
                        app_pwr = s[0] ? at - 25'h1 : at + 25'h1;
                    end
                    seen = 8'h00;
                    tick();
                    `CHK(seen & 8'h24, s[0] ? 8'h24 : 8'h00)
                end
            end
        end
    endtask

    task automatic test_cycle_end();
        pc1 = 8'h80;
        line_num = 16'h0003;
        for (int d = 0; d < 2; d++) begin
            cyc_dis = d[0];
            ce_cnt = 0;
            repeat (6) begin
                half_cyc = 1'b1;
                cyc(1);
                half_cyc = 1'b0;
                cyc(2);
            end
            cyc(2);
            `CHK(ce_cnt, (d != 0) ? 0 : 2)
        end
    endtask

    task automatic test_wave();
        samp_en = 1'b1;
        seen = 8'h00;
        cyc(3*SAMP);
        `CHK(wva, 25'h0abc00)
        `CHK(wvb, 25'h0abc05)
        `CHK(seen[7], 1'b1)
        seen = 8'h00;
        cyc(3*SAMP);
        `CHK(seen[7], 1'b0)
        sdata[5] = 25'h155555;
        cyc(3*SAMP);
        `CHK(seen[7], 1'b1)
        `CHK(wvb, 25'h155555)
        // Master enable off freezes the sample registers
        pc1 = 8'h00;
        sdata[0] = 25'h000000;
        cyc(3*SAMP);
        `CHK(wva, 25'h0abc00)
    endtask

    initial begin
        mclk_i = 1'b0;
        sys_rst_i = 1'b1;
        {acc_tick, half_cyc, cyc_dis, samp_en} = 4'h0;
        {pc1, pc2, cmr2} = 24'h0;
        {rea_code, app_code, rea_top, app_top} = 8'h00;
        line_num = 16'h0003;
        {rea_pwr, app_pwr} = {25'h0100000, 25'h0100000};
        irms = 23'h7ffff;
        sel[0] = 3'h0;
        sel[1] = 3'h5;
        for (int k = 0; k < 8; k++) sdata[k] = 25'h0abc00 + 25'(k);
        {seen, ce_cnt, failures, cmp_count} = '0;
        repeat (6) @(posedge mclk_i);
        #1;
        sys_rst_i = 1'b0;
        cyc(1);
        `CHK(evbus, 8'h00)
        `CHK(wva, 25'h0)
        test_enables();
        test_accum();
        test_noload();
        test_cycle_end();
        test_wave();
        give_verdict();
    end

    // About eighteen times the expected run length
    initial begin
        #20000;
        failures++;
        give_verdict();
    end
endmodule
